// ==== hdl/switch_queue_vlan_entry_params.svh ====
`ifndef SWITCH_QUEUE_VLAN_ENTRY_PARAMS_SVH
`define SWITCH_QUEUE_VLAN_ENTRY_PARAMS_SVH
// register byte offsets
`define QCTL_OFF     16'h0390
`define ENTRY0_OFF   16'h0400
`define ENTRY2_OFF   16'h0408
`define ACCESS_OFF   16'h040c
// reset values
`define QCTL_RST     8'h82
// queue control fields
`define MAP_LSB      6
`define DISC_BIT     1
// staged entry fields
`define VALID_BIT    31
`define FO_BIT       27
`define PRIO_LSB     24
`define MSTI_LSB     12
`define FID_LSB      0
// access word fields
`define INDEX_LSB    0
`define ACT_LSB      16
`define START_BIT    23
`endif

// ==== hdl/switch_queue_vlan_entry_pkg.sv ====
package switch_queue_vlan_entry_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_REQ  = 2'b01,
    ST_WAIT = 2'b10
  } fsm_e;

  typedef enum logic [1:0] {
    ACT_NONE  = 2'b00,
    ACT_WRITE = 2'b01,
    ACT_READ  = 2'b10,
    ACT_CLEAR = 2'b11
  } act_e;

  typedef enum logic [1:0] {
    MAP_012_3 = 2'b00,
    MAP_UNUSED = 2'b01,
    MAP_01_23 = 2'b10,
    MAP_0_123 = 2'b11
  } map_e;

  typedef struct packed {
    logic [15:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
  } apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_s;

  typedef struct packed {
    logic       valid;
    logic       fo;
    logic [2:0] prio;
    logic [2:0] msti;
    logic [6:0] filter_identifier;
    logic [6:0] fwd;
  } vlan_entry_s;

  typedef struct packed {
    logic [1:0]  prio;
    logic [6:0]  dest;
    logic [6:0]  member;
    logic        mirror_en;
    logic        mirrored;
    logic [47:0] dest_addr;
  } frame_in_s;

  typedef struct packed {
    logic       high_q;
    logic [6:0] fwd;
    logic       drop;
    logic [9:0] hash;
  } frame_out_s;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic        clr;
    logic [11:0] index;
    vlan_entry_s wdata;
  } tbl_req_s;

  typedef struct packed {
    logic        done;
    vlan_entry_s rdata;
  } tbl_rsp_s;

endpackage : switch_queue_vlan_entry_pkg

// ==== hdl/switch_queue_vlan_entry_regs.sv ====
// Function
// - two-bit queue map field at bits 7:6
// - map 00: only priority three high
// - map 10: priorities two, three high
// - map 11: priorities one to three high
// - discard set: confine frames to membership
// - discard clear: single-destination frames not masked by membership
// - discard clear: mirrored single-destination frame dropped
// - entry bit 31 is valid flag
// - override flag forwards to entry mask
// - override clear: forwarding from other sources
// - entry priority at bits 26:24
// - spanning tree index at bits 14:12
// - filter identifier hashed with destination address
// - entry mask applies only with override
// - twelve-bit index selects table entry
// - start bit self-clears when action completes
`timescale 1ns/100ps
`include "switch_queue_vlan_entry_params.svh"

module switch_queue_vlan_entry_regs (
  input  wire logic                                CLOCK,
  input  wire logic                                ARST_N,
  input  wire logic                                CE,
  input  wire switch_queue_vlan_entry_pkg::apb_req_s   APB_REQ,
  output      switch_queue_vlan_entry_pkg::apb_rsp_s   APB_RSP,
  input  wire switch_queue_vlan_entry_pkg::frame_in_s  FRAME_IN,
  output      switch_queue_vlan_entry_pkg::frame_out_s FRAME_OUT,
  output      switch_queue_vlan_entry_pkg::tbl_req_s   TBL_REQ,
  input  wire switch_queue_vlan_entry_pkg::tbl_rsp_s   TBL_RSP
);

  typedef struct packed {
    logic [7:0]                              qctl;
    switch_queue_vlan_entry_pkg::vlan_entry_s ent;
    logic [11:0]                             index;
    logic                                    start;
    logic [1:0]                              action;
    switch_queue_vlan_entry_pkg::fsm_e       fsm;
    switch_queue_vlan_entry_pkg::apb_rsp_s   rsp;
    switch_queue_vlan_entry_pkg::frame_out_s fout;
    switch_queue_vlan_entry_pkg::tbl_req_s   treq;
  } state_s;

  localparam state_s S_RST = '{
    qctl:    `QCTL_RST,
    fsm:     switch_queue_vlan_entry_pkg::ST_IDLE,
    default: '0
  };

  state_s s_q;
  state_s s_d;

  // byte-lane merge of a write into an old word
  function automatic logic [31:0] merge_f(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge_f

  // staged entry word, reserved bits zero
  function automatic logic [31:0] e0_word_f(
      input switch_queue_vlan_entry_pkg::vlan_entry_s e);
    logic [31:0] v;
    v = 32'h0;
    v[`VALID_BIT] = e.valid;
    v[`FO_BIT] = e.fo;
    v[`PRIO_LSB +: 3] = e.prio;
    v[`MSTI_LSB +: 3] = e.msti;
    v[`FID_LSB +: 7] = e.filter_identifier;
    return v;
  endfunction : e0_word_f

  // priority to queue: one means high queue
  function automatic logic hi_q_f(input logic [1:0] map, input logic [1:0] prio);
    logic h;
    case (map)
      switch_queue_vlan_entry_pkg::MAP_012_3: h = (prio == 2'h3);
      switch_queue_vlan_entry_pkg::MAP_0_123: h = (prio != 2'h0);
      default:                                h = (prio >= 2'h2);
    endcase
    return h;
  endfunction : hi_q_f

  // exactly one destination port
  function automatic logic one_port_f(input logic [6:0] m);
    return (m != 7'h0) && ((m & 7'(m - 7'h1)) == 7'h0);
  endfunction : one_port_f

  // fold address and filter id into a lookup index
  function automatic logic [9:0] hash_f(input logic [6:0]  filter_identifier,
                                        input logic [47:0] da);
    return da[9:0] ^ da[19:10] ^ da[29:20] ^ da[39:30]
         ^ {2'h0, da[47:40]} ^ {3'h0, filter_identifier};
  endfunction : hash_f

  logic        acc;
  logic        wr_fire;
  logic        sel_qctl;
  logic        sel_e0;
  logic        sel_e2;
  logic        sel_acc;
  logic [31:0] acc_word;
  logic [31:0] rd_word;
  logic [31:0] w;
  logic [6:0]  base;

  // address decode and read mux
  always_comb
  begin
    sel_qctl = (APB_REQ.paddr[15:2] == 14'(`QCTL_OFF >> 2));
    sel_e0   = (APB_REQ.paddr[15:2] == 14'(`ENTRY0_OFF >> 2));
    sel_e2   = (APB_REQ.paddr[15:2] == 14'(`ENTRY2_OFF >> 2));
    sel_acc  = (APB_REQ.paddr[15:2] == 14'(`ACCESS_OFF >> 2));
    acc_word = 32'h0;
    acc_word[`INDEX_LSB +: 12] = s_q.index;
    acc_word[`ACT_LSB +: 2] = s_q.action;
    acc_word[`START_BIT] = s_q.start;
    rd_word = 32'h0;
    if (sel_qctl)
    begin
      rd_word[7:0] = s_q.qctl;
    end
    else if (sel_e0)
    begin
      rd_word = e0_word_f(s_q.ent);
    end
    else if (sel_e2)
    begin
      rd_word[6:0] = s_q.ent.fwd;
    end
    else if (sel_acc)
    begin
      rd_word = acc_word;
    end
  end

  // next state of the whole block
  always_comb
  begin
    s_d = s_q;
    w = 32'h0;
    s_d.treq.wr = 1'b0;
    s_d.treq.rd = 1'b0;
    s_d.treq.clr = 1'b0;
    acc = APB_REQ.psel && APB_REQ.penable;
    wr_fire = acc && s_q.rsp.pready && APB_REQ.pwrite && !s_q.rsp.pslverr;

    // apb answer one cycle into the access phase
    s_d.rsp.pready = acc && !s_q.rsp.pready;
    if (acc && !s_q.rsp.pready)
    begin
      s_d.rsp.pslverr = !(sel_qctl || sel_e0 || sel_e2 || sel_acc);
      s_d.rsp.prdata = APB_REQ.pwrite ? 32'h0 : rd_word;
    end

    // register writes at the completing edge
    if (wr_fire)
    begin
      if (sel_qctl)
      begin
        w = merge_f({24'h0, s_q.qctl}, APB_REQ.pwdata, APB_REQ.pstrb);
        s_d.qctl = w[7:0];
      end
      else if (sel_e0)
      begin
        w = merge_f(e0_word_f(s_q.ent), APB_REQ.pwdata, APB_REQ.pstrb);
        s_d.ent.valid = w[`VALID_BIT];
        s_d.ent.fo = w[`FO_BIT];
        s_d.ent.prio = w[`PRIO_LSB +: 3];
        s_d.ent.msti = w[`MSTI_LSB +: 3];
        s_d.ent.filter_identifier = w[`FID_LSB +: 7];
      end
      else if (sel_e2)
      begin
        w = merge_f({25'h0, s_q.ent.fwd}, APB_REQ.pwdata, APB_REQ.pstrb);
        s_d.ent.fwd = w[6:0];
      end
      else if (sel_acc && s_q.fsm == switch_queue_vlan_entry_pkg::ST_IDLE
               && !s_q.start)
      begin
        w = merge_f(acc_word, APB_REQ.pwdata, APB_REQ.pstrb);
        s_d.index = w[`INDEX_LSB +: 12];
        s_d.action = w[`ACT_LSB +: 2];
        s_d.start = w[`START_BIT];
      end
    end

    // table access sequencer
    case (s_q.fsm)
      switch_queue_vlan_entry_pkg::ST_IDLE:
      begin
        if (s_q.start)
        begin
          if (s_q.action == switch_queue_vlan_entry_pkg::ACT_NONE)
          begin
            s_d.start = 1'b0;
          end
          else
          begin
            s_d.fsm = switch_queue_vlan_entry_pkg::ST_REQ;
          end
        end
      end
      switch_queue_vlan_entry_pkg::ST_REQ:
      begin
        s_d.treq.wr = (s_q.action == switch_queue_vlan_entry_pkg::ACT_WRITE);
        s_d.treq.rd = (s_q.action == switch_queue_vlan_entry_pkg::ACT_READ);
        s_d.treq.clr = (s_q.action == switch_queue_vlan_entry_pkg::ACT_CLEAR);
        s_d.treq.index = s_q.index;
        s_d.treq.wdata = s_q.ent;
        s_d.fsm = switch_queue_vlan_entry_pkg::ST_WAIT;
      end
      switch_queue_vlan_entry_pkg::ST_WAIT:
      begin
        if (TBL_RSP.done)
        begin
          if (s_q.action == switch_queue_vlan_entry_pkg::ACT_READ)
          begin
            s_d.ent = TBL_RSP.rdata;
          end
          s_d.start = 1'b0;
          s_d.fsm = switch_queue_vlan_entry_pkg::ST_IDLE;
        end
      end
      default:
      begin
        s_d.fsm = switch_queue_vlan_entry_pkg::ST_IDLE;
      end
    endcase

    // frame path: forwarding set, drop and queue choice
    base = s_q.ent.fo ? s_q.ent.fwd : FRAME_IN.dest;
    s_d.fout.drop = 1'b0;
    if (s_q.qctl[`DISC_BIT])
    begin
      s_d.fout.fwd = base & FRAME_IN.member;
    end
    else if (one_port_f(base))
    begin
      if (FRAME_IN.mirror_en && FRAME_IN.mirrored)
      begin
        s_d.fout.fwd = 7'h0;
        s_d.fout.drop = 1'b1;
      end
      else
      begin
        s_d.fout.fwd = base;
      end
    end
    else
    begin
      s_d.fout.fwd = base & FRAME_IN.member;
    end
    s_d.fout.high_q = hi_q_f(s_q.qctl[`MAP_LSB +: 2], FRAME_IN.prio);
    s_d.fout.hash = hash_f(s_q.ent.filter_identifier, FRAME_IN.dest_addr);
  end

  // state register, frozen while the clock enable is low
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      s_q <= S_RST;
    end
    else if (CE)
    begin
      s_q <= s_d;
    end
  end

  assign APB_RSP   = s_q.rsp;
  assign FRAME_OUT = s_q.fout;
  assign TBL_REQ   = s_q.treq;

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);

  property p_map00;
    CE && s_q.qctl[`MAP_LSB +: 2] == 2'b00 && FRAME_IN.prio == 2'h2 |=> !FRAME_OUT.high_q;
  endproperty
  a_map00: assert property (p_map00)
    else $error("map 00 put priority two in high queue");

  property p_map10;
    CE && s_q.qctl[`MAP_LSB +: 2] == 2'b10 && FRAME_IN.prio == 2'h2 |=> FRAME_OUT.high_q;
  endproperty
  a_map10: assert property (p_map10)
    else $error("map 10 put priority two in low queue");

  property p_map11;
    CE && s_q.qctl[`MAP_LSB +: 2] == 2'b11 && FRAME_IN.prio == 2'h1 |=> FRAME_OUT.high_q;
  endproperty
  a_map11: assert property (p_map11)
    else $error("map 11 put priority one in low queue");

  property p_disc;
    CE && s_q.qctl[`DISC_BIT] |=> (FRAME_OUT.fwd & ~$past(FRAME_IN.member)) == 7'h0
                                  && !FRAME_OUT.drop;
  endproperty
  a_disc: assert property (p_disc)
    else $error("frame left membership set while discard set");

  property p_mirror;
    CE && !s_q.qctl[`DISC_BIT] && one_port_f(base) && FRAME_IN.mirror_en
    && FRAME_IN.mirrored |=> FRAME_OUT.drop && FRAME_OUT.fwd == 7'h0;
  endproperty
  a_mirror: assert property (p_mirror)
    else $error("mirrored single-destination frame not dropped");

  property p_fo;
    CE && s_q.ent.fo && !s_q.qctl[`DISC_BIT] && !one_port_f(base)
    |=> (FRAME_OUT.fwd & ~$past(s_q.ent.fwd)) == 7'h0;
  endproperty
  a_fo: assert property (p_fo)
    else $error("override set but forwarded outside entry mask");

  property p_valid_rd;
    CE && APB_REQ.psel && APB_REQ.penable && !APB_RSP.pready && !APB_REQ.pwrite
    && APB_REQ.paddr == `ENTRY0_OFF |=> APB_RSP.prdata[31] == $past(s_q.ent.valid);
  endproperty
  a_valid_rd: assert property (p_valid_rd)
    else $error("valid flag not read back at bit 31");

  property p_index;
    CE && s_q.fsm == switch_queue_vlan_entry_pkg::ST_REQ
    |=> TBL_REQ.index == $past(s_q.index);
  endproperty
  a_index: assert property (p_index)
    else $error("table request carries wrong index");

  sequence s_req;
    CE && s_q.fsm == switch_queue_vlan_entry_pkg::ST_REQ;
  endsequence
  sequence s_pulse;
    (TBL_REQ.wr || TBL_REQ.rd || TBL_REQ.clr) && s_q.start ##1 !TBL_REQ.wr
    && !TBL_REQ.rd && !TBL_REQ.clr;
  endsequence
  property p_req;
    s_req ##1 CE |-> s_pulse;
  endproperty
  a_req: assert property (p_req)
    else $error("table request not a single pulse");
  sequence s_done;
    CE && s_q.fsm == switch_queue_vlan_entry_pkg::ST_WAIT && TBL_RSP.done;
  endsequence
  property p_done;
    s_done |=> !s_q.start && s_q.fsm == switch_queue_vlan_entry_pkg::ST_IDLE;
  endproperty
  a_done: assert property (p_done)
    else $error("start bit not cleared at completion");

  property p_ready;
    CE && APB_RSP.pready |=> !APB_RSP.pready;
  endproperty
  a_ready: assert property (p_ready)
    else $error("pready held for two cycles");

endmodule : switch_queue_vlan_entry_regs

// ==== bench/tb_switch_queue_vlan_entry_regs.sv ====
`timescale 1ns/100ps

module tb_switch_queue_vlan_entry_regs;

  logic                                     clock;
  logic                                     arst_n;
  logic                                     ce;
  switch_queue_vlan_entry_pkg::apb_req_s    req;
  switch_queue_vlan_entry_pkg::apb_rsp_s    rsp;
  switch_queue_vlan_entry_pkg::frame_in_s   fin;
  switch_queue_vlan_entry_pkg::frame_out_s  fout;
  switch_queue_vlan_entry_pkg::tbl_req_s    treq;
  switch_queue_vlan_entry_pkg::tbl_rsp_s    trsp;
  int                                       n_fail;
  int                                       tests_run;
  int                                       cyc;
  logic [31:0]                              rd;
  logic                                     err;

  switch_queue_vlan_entry_regs DUT (
    .CLOCK     (clock),
    .ARST_N    (arst_n),
    .CE        (ce),
    .APB_REQ   (req),
    .APB_RSP   (rsp),
    .FRAME_IN  (fin),
    .FRAME_OUT (fout),
    .TBL_REQ   (treq),
    .TBL_RSP   (trsp)
  );

  // free-running clock, 10 ns period
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // prints the verdict and ends the run
  task finish_test;
    if (n_fail == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test

  // cuts a hung run short
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail = n_fail + 1;
      finish_test();
    end
  end

  // compares seen against expected
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp)
    begin
      n_fail = n_fail + 1;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer, held until pready is sampled high
  task apb(input logic wr, input logic [15:0] a, input logic [31:0] wd);
    @(posedge clock);
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= wr;
    req.paddr   <= a;
    req.pwdata  <= wd;
    @(posedge clock);
    req.penable <= 1'b1;
    do @(posedge clock); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  task wreg(input logic [15:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wreg

  task rchk(input logic [15:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rchk

  // presents one frame and waits for its registered result
  task frm(input logic [1:0] p, input logic [6:0] d, input logic [6:0] m,
           input logic me, input logic mi);
    @(posedge clock);
    fin.prio      <= p;
    fin.dest      <= d;
    fin.member    <= m;
    fin.mirror_en <= me;
    fin.mirrored  <= mi;
    @(posedge clock);
    @(posedge clock);
  endtask : frm

  // expected queue for a map code and a priority
  function automatic logic hq(input logic [1:0] m, input logic [1:0] p);
    case (m)
      2'b00:   return p == 2'd3;
      2'b11:   return p != 2'd0;
      default: return p >= 2'd2;
    endcase
  endfunction : hq

  // starts a table action, answers it and waits for start to clear
  task act(input logic [31:0] w, input logic [2:0] kind, input logic [21:0] exp_wd,
           input logic [21:0] rsp_d);
    int k;
    wreg(16'h040c, w);
    k = 0;
    while ({treq.wr, treq.rd, treq.clr} === 3'b000 && k < 50)
    begin
      @(posedge clock);
      k = k + 1;
    end
    chk(32'({treq.wr, treq.rd, treq.clr}), 32'(kind));
    chk(32'(treq.index), 32'(w[11:0]));
    if (kind[2])
      chk(32'(treq.wdata), 32'(exp_wd));
    wreg(16'h040c, 32'h0000_0123);
    trsp.done  <= 1'b1;
    trsp.rdata <= rsp_d;
    @(posedge clock);
    trsp.done  <= 1'b0;
    k = 0;
    do
    begin
      apb(1'b0, 16'h040c, 32'h0);
      k = k + 1;
    end
    while (rd[23] !== 1'b0 && k < 20);
    chk(rd, w & 32'hff7f_ffff);
  endtask : act

  // main sequence
  initial
  begin
    arst_n = 1'b0;
    ce = 1'b1;
    req = '0;
    req.pstrb = 4'hf;
    fin = '0;
    trsp = '0;
    n_fail = 0;
    tests_run = 0;
    repeat (20) @(posedge clock);
    arst_n <= 1'b1;
    rchk(16'h0390, 32'h0000_0082);
    rchk(16'h0400, 32'h0000_0000);
    apb(1'b0, 16'h0500, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    wreg(16'h0400, 32'hffff_ffff);
    rchk(16'h0400, 32'h8f00_707f);
    wreg(16'h0400, 32'h0);
    // every map code against every priority
    for (int m = 0; m < 4; m++)
    begin
      wreg(16'h0390, {24'h0, 2'(m), 6'h02});
      for (int p = 0; p < 4; p++)
      begin
        frm(2'(p), 7'h01, 7'h7f, 1'b0, 1'b0);
        chk(32'(fout.high_q), 32'(hq(2'(m), 2'(p))));
      end
    end
    // membership discard and mirroring
    wreg(16'h0390, 32'h82);
    frm(2'd0, 7'h01, 7'h02, 1'b0, 1'b0);
    chk(32'({fout.drop, fout.fwd}), 32'h00);
    wreg(16'h0390, 32'h80);
    frm(2'd0, 7'h01, 7'h02, 1'b0, 1'b0);
    chk(32'({fout.drop, fout.fwd}), 32'h01);
    frm(2'd0, 7'h01, 7'h02, 1'b1, 1'b1);
    chk(32'({fout.drop, fout.fwd}), 32'h80);
    frm(2'd0, 7'h01, 7'h02, 1'b1, 1'b0);
    chk(32'({fout.drop, fout.fwd}), 32'h01);
    frm(2'd0, 7'h03, 7'h02, 1'b0, 1'b0);
    chk(32'({fout.drop, fout.fwd}), 32'h02);
    // override flag selects the entry mask
    wreg(16'h0408, 32'h55);
    wreg(16'h0400, 32'h0800_0000);
    wreg(16'h0390, 32'h82);
    frm(2'd0, 7'h0f, 7'h7f, 1'b0, 1'b0);
    chk(32'(fout.fwd), 32'h55);
    wreg(16'h0390, 32'h80);
    frm(2'd0, 7'h0f, 7'h0f, 1'b0, 1'b0);
    chk(32'(fout.fwd), 32'h05);
    wreg(16'h0400, 32'h0);
    frm(2'd0, 7'h0f, 7'h7f, 1'b0, 1'b0);
    chk(32'(fout.fwd), 32'h0f);
    chk(32'(fout.hash), 32'h0);
    // clock enable low freezes the frame result
    ce <= 1'b0;
    frm(2'd3, 7'h01, 7'h7f, 1'b0, 1'b0);
    chk(32'({fout.high_q, fout.fwd}), 32'h0f);
    ce <= 1'b1;
    // table actions: none, write, read, clear
    wreg(16'h040c, 32'h0080_0005);
    rchk(16'h040c, 32'h0000_0005);
    wreg(16'h0400, 32'h8500_302a);
    act(32'h0081_0abc, 3'b100, {1'b1, 1'b0, 3'd5, 3'd3, 7'h2a, 7'h55}, 22'h0);
    act(32'h0082_0123, 3'b010, 22'h0, {1'b0, 1'b1, 3'd2, 3'd6, 7'h11, 7'h22});
    rchk(16'h0400, 32'h0a00_6011);
    rchk(16'h0408, 32'h0000_0022);
    fin.dest_addr <= 48'h0000_0000_0300;
    frm(2'd0, 7'h0f, 7'h7f, 1'b0, 1'b0);
    chk(32'(fout.hash), 32'h311);
    act(32'h0083_0fff, 3'b001, 22'h0, 22'h0);
    finish_test();
  end

endmodule : tb_switch_queue_vlan_entry_regs
